// file: logic/eemac_pkg.sv
// Purpose: Constants and types for the nonvolatile memory access control block
// Assumes: 8-bit register port, registers at word indices chosen here
// Notes: One localparam per number; modules import the whole package
package eemac_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [3:0] EEMAC_ADDR_DATA_LOW = 4'h0;
    localparam logic [3:0] EEMAC_ADDR_DATA_HIGH = 4'h1;
    localparam logic [3:0] EEMAC_ADDR_ADDR_LOW = 4'h2;
    localparam logic [3:0] EEMAC_ADDR_ADDR_HIGH = 4'h3;
    localparam logic [3:0] EEMAC_ADDR_CONTROL = 4'h4;
    localparam logic [3:0] EEMAC_ADDR_IRQ_STATUS = 4'h5;
    localparam logic [3:0] EEMAC_ADDR_IRQ_MASK = 4'h6;

    // ----------------------------------------
    // Field layout
    // ----------------------------------------
    localparam int EEMAC_CTL_MEM_SEL = 7;
    localparam int EEMAC_CTL_WR_ERR = 3;
    localparam int EEMAC_CTL_WR_PERMIT = 2;
    localparam int EEMAC_CTL_WR_TRIG = 1;
    localparam int EEMAC_CTL_RD_TRIG = 0;
    localparam logic [7:0] EEMAC_DATA_HIGH_MASK = 8'h3F;
    localparam logic [7:0] EEMAC_ADDR_HIGH_MASK = 8'h1F;
    localparam int EEMAC_IRQ_RD_DONE = 0;
    localparam int EEMAC_IRQ_WR_DONE = 1;
    localparam int EEMAC_IRQ_WR_ERR = 2;
    localparam int EEMAC_IRQ_WR_BLOCKED = 3;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] EEMAC_RST_BYTE = 8'h00;
    localparam logic [3:0] EEMAC_RST_IRQ = 4'h0;

    typedef enum logic [1:0] {
        EEMAC_IDLE = 2'b00,
        EEMAC_READ = 2'b01,
        EEMAC_WRITE = 2'b11
    } eemac_state_t;

endpackage

// file: logic/eemac_irq.sv
// Purpose: Sticky event status with mask and level interrupt
// Assumes: Status clears on a read of it; a new event wins over that clear
// Notes: Four event sources
`timescale 1ns/1ps
module eemac_irq
    import eemac_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] events,
    input wire logic status_rd,
    input wire logic mask_wr,
    input wire logic [3:0] mask_wdata,
    output logic [3:0] status,
    output logic [3:0] mask,
    output logic irq
);

    typedef struct packed {
        logic [3:0] status;
        logic [3:0] mask;
    } eemac_irq_st_t;

    eemac_irq_st_t st_q;
    eemac_irq_st_t st_d;

    always_comb begin
        st_d = st_q;
        if (status_rd) begin
            st_d.status = 4'h0;
        end
        // Set wins over read clear
        st_d.status = st_d.status | events;
        if (mask_wr) begin
            st_d.mask = mask_wdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= '{status: EEMAC_RST_IRQ, mask: EEMAC_RST_IRQ};
        end else begin
            st_q <= st_d;
        end
    end

    assign status = st_q.status;
    assign mask = st_q.mask;
    assign irq = |(st_q.status & st_q.mask);

endmodule

// file: logic/eemac_ctrl.sv
// Purpose: Indirect access control for data EEPROM and program flash
// Assumes: Arrays answer reads combinationally; write done is a pulse
// Notes: Unlock sequence and program-read stall live outside this block
`timescale 1ns/1ps
module eemac_ctrl
    import eemac_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic por,
    input wire logic external_master_reset,
    input wire logic watchdog_timeout,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic irq,
    output logic [12:0] mem_addr,
    output logic [7:0] mem_wdata,
    output logic ee_rd,
    output logic ee_wr,
    output logic prog_rd,
    input wire logic [7:0] ee_rdata,
    input wire logic [13:0] prog_rdata,
    input wire logic ee_wr_done
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        eemac_state_t state;
        logic [7:0] data_low;
        logic [7:0] data_high;
        logic [7:0] addr_low;
        logic [7:0] addr_high;
        logic mem_sel;
        logic wr_err;
        logic wr_permit;
        logic wr_trig;
        logic rd_trig;
        logic [7:0] rdata;
    } eemac_st_t;

    eemac_st_t st_q;
    eemac_st_t st_d;

    logic [3:0] irq_status;
    logic [3:0] irq_mask;
    logic [3:0] irq_events;
    logic status_rd;
    logic mask_wr;
    logic wr_start;
    logic wr_blocked;
    logic wr_abort;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        return a == off;
    endfunction

    function automatic logic [7:0] ctl_byte(input eemac_st_t s);
        logic [7:0] b;
        b = 8'h00;
        b[EEMAC_CTL_MEM_SEL] = s.mem_sel;
        b[EEMAC_CTL_WR_ERR] = s.wr_err;
        b[EEMAC_CTL_WR_PERMIT] = s.wr_permit;
        b[EEMAC_CTL_WR_TRIG] = s.wr_trig;
        b[EEMAC_CTL_RD_TRIG] = s.rd_trig;
        return b;
    endfunction

    wire logic ctl_wr = reg_wr && hit(reg_addr, EEMAC_ADDR_CONTROL);
    // Only data EEPROM is writable; program writes and unpermitted writes are dropped
    assign wr_start = ctl_wr && reg_wdata[EEMAC_CTL_WR_TRIG] && !st_q.wr_trig
        && st_q.wr_permit && !st_q.mem_sel;
    assign wr_blocked = ctl_wr && reg_wdata[EEMAC_CTL_WR_TRIG] && !st_q.wr_trig && !wr_start;
    assign wr_abort = st_q.wr_trig && (external_master_reset || watchdog_timeout);
    assign status_rd = reg_rd && hit(reg_addr, EEMAC_ADDR_IRQ_STATUS);
    assign mask_wr = reg_wr && hit(reg_addr, EEMAC_ADDR_IRQ_MASK);

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        st_d = st_q;
        irq_events = 4'h0;
        if (reg_wr) begin
            case (reg_addr)
                EEMAC_ADDR_DATA_LOW: begin
                    st_d.data_low = reg_wdata;
                end
                EEMAC_ADDR_DATA_HIGH: begin
                    st_d.data_high = reg_wdata & EEMAC_DATA_HIGH_MASK;
                end
                EEMAC_ADDR_ADDR_LOW: begin
                    st_d.addr_low = reg_wdata;
                end
                EEMAC_ADDR_ADDR_HIGH: begin
                    st_d.addr_high = reg_wdata & EEMAC_ADDR_HIGH_MASK;
                end
                EEMAC_ADDR_CONTROL: begin
                    st_d.mem_sel = reg_wdata[EEMAC_CTL_MEM_SEL];
                    st_d.wr_permit = reg_wdata[EEMAC_CTL_WR_PERMIT];
                    // Software may clear the error flag but not set it
                    if (!reg_wdata[EEMAC_CTL_WR_ERR]) begin
                        st_d.wr_err = 1'b0;
                    end
                    if (reg_wdata[EEMAC_CTL_RD_TRIG] && st_q.state == EEMAC_IDLE) begin
                        st_d.rd_trig = 1'b1;
                        st_d.state = EEMAC_READ;
                    end
                    if (wr_start && st_q.state == EEMAC_IDLE
                        && !reg_wdata[EEMAC_CTL_RD_TRIG]) begin
                        st_d.wr_trig = 1'b1;
                        st_d.state = EEMAC_WRITE;
                    end
                end
                default: begin
                end
            endcase
        end
        case (st_q.state)
            EEMAC_READ: begin
                // Array data captured here; the byte is readable the next cycle
                st_d.data_low = st_q.mem_sel ? prog_rdata[7:0] : ee_rdata;
                if (st_q.mem_sel) begin
                    st_d.data_high = {2'b00, prog_rdata[13:8]};
                end
                st_d.rd_trig = 1'b0;
                st_d.state = EEMAC_IDLE;
                irq_events[EEMAC_IRQ_RD_DONE] = 1'b1;
            end
            EEMAC_WRITE: begin
                if (wr_abort) begin
                    st_d.wr_err = 1'b1;
                    st_d.wr_trig = 1'b0;
                    st_d.state = EEMAC_IDLE;
                    irq_events[EEMAC_IRQ_WR_ERR] = 1'b1;
                end else if (ee_wr_done) begin
                    st_d.wr_trig = 1'b0;
                    st_d.state = EEMAC_IDLE;
                    irq_events[EEMAC_IRQ_WR_DONE] = 1'b1;
                end
            end
            default: begin
            end
        endcase
        if (wr_blocked) begin
            irq_events[EEMAC_IRQ_WR_BLOCKED] = 1'b1;
        end
        // ----------------------------------------
        // Read data, one cycle after the strobe
        // ----------------------------------------
        st_d.rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                // Next-state copy, so a read right behind the trigger sees the new byte
                EEMAC_ADDR_DATA_LOW: st_d.rdata = st_d.data_low;
                EEMAC_ADDR_DATA_HIGH: st_d.rdata = st_d.data_high & EEMAC_DATA_HIGH_MASK;
                EEMAC_ADDR_ADDR_LOW: st_d.rdata = st_q.addr_low;
                EEMAC_ADDR_ADDR_HIGH: st_d.rdata = st_q.addr_high & EEMAC_ADDR_HIGH_MASK;
                EEMAC_ADDR_CONTROL: st_d.rdata = ctl_byte(st_q);
                EEMAC_ADDR_IRQ_STATUS: st_d.rdata = {4'h0, irq_status};
                EEMAC_ADDR_IRQ_MASK: st_d.rdata = {4'h0, irq_mask};
                default: st_d.rdata = 8'h00;
            endcase
        end
    end

    // Power-up and rst both clear the permit; master reset and watchdog leave it and keep the error flag
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= '{state: EEMAC_IDLE, data_low: EEMAC_RST_BYTE,
                data_high: EEMAC_RST_BYTE, addr_low: EEMAC_RST_BYTE,
                addr_high: EEMAC_RST_BYTE, rdata: EEMAC_RST_BYTE, default: 1'b0};
        end else if (por) begin
            st_q <= '{state: EEMAC_IDLE, data_low: EEMAC_RST_BYTE,
                data_high: EEMAC_RST_BYTE, addr_low: EEMAC_RST_BYTE,
                addr_high: EEMAC_RST_BYTE, rdata: EEMAC_RST_BYTE, default: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    eemac_irq u_irq (
        .clk(clk),
        .rst(rst),
        .events(irq_events),
        .status_rd(status_rd),
        .mask_wr(mask_wr),
        .mask_wdata(reg_wdata[3:0]),
        .status(irq_status),
        .mask(irq_mask),
        .irq(irq)
    );

    // ----------------------------------------
    // Array side
    // ----------------------------------------
    assign mem_addr = {st_q.addr_high[4:0], st_q.addr_low};
    assign mem_wdata = st_q.data_low;
    assign ee_rd = (st_q.state == EEMAC_READ) && !st_q.mem_sel;
    assign prog_rd = (st_q.state == EEMAC_READ) && st_q.mem_sel;
    assign ee_wr = (st_q.state == EEMAC_WRITE);
    assign reg_rdata = st_q.rdata;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_rd_set;
        reg_wr && reg_addr == EEMAC_ADDR_CONTROL && reg_wdata[0] && st_q.state == EEMAC_IDLE;
    endsequence

    property p_dh_zero;
        @(posedge clk) disable iff (rst) st_q.data_high[7:6] == 2'b00;
    endproperty
    a_dh_zero: assert property (p_dh_zero) else $error("data high top bits set");

    property p_ah_zero;
        @(posedge clk) disable iff (rst) st_q.addr_high[7:5] == 3'b000;
    endproperty
    a_ah_zero: assert property (p_ah_zero) else $error("address high top bits set");

    property p_sel_steer;
        @(posedge clk) disable iff (rst) st_q.state == EEMAC_READ |-> prog_rd == st_q.mem_sel;
    endproperty
    a_sel_steer: assert property (p_sel_steer) else $error("read steered wrong");

    property p_err_set;
        @(posedge clk) disable iff (rst || por) wr_abort && st_q.state == EEMAC_WRITE
            |=> st_q.wr_err && !st_q.wr_trig;
    endproperty
    a_err_set: assert property (p_err_set) else $error("aborted write not flagged");

    property p_permit;
        @(posedge clk) disable iff (rst) $rose(st_q.wr_trig) |-> $past(st_q.wr_permit);
    endproperty
    a_permit: assert property (p_permit) else $error("write started without permit");

    property p_wr_hold;
        @(posedge clk) disable iff (rst || por)
            st_q.wr_trig && !ee_wr_done && !wr_abort |=> st_q.wr_trig;
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write trigger dropped early");

    property p_rd_pulse;
        @(posedge clk) disable iff (rst || por) s_rd_set |=> st_q.rd_trig ##1 !st_q.rd_trig;
    endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("read trigger not one cycle");

    property p_rd_data;
        @(posedge clk) disable iff (rst || por) ee_rd |=> st_q.data_low == $past(ee_rdata);
    endproperty
    a_rd_data: assert property (p_rd_data) else $error("read byte not captured");

    property p_hold;
        @(posedge clk) disable iff (rst || por)
            st_q.state == EEMAC_IDLE && !(reg_wr && reg_addr == EEMAC_ADDR_DATA_LOW)
            |=> $stable(st_q.data_low);
    endproperty
    a_hold: assert property (p_hold) else $error("data register changed");

    property p_rd_next;
        @(posedge clk) disable iff (rst || por)
            ee_rd && reg_rd && reg_addr == EEMAC_ADDR_DATA_LOW
            |=> reg_rdata == $past(ee_rdata);
    endproperty
    a_rd_next: assert property (p_rd_next) else $error("read byte late on the port");

    property p_ctl_gap;
        @(posedge clk) disable iff (rst || por)
            reg_rd && reg_addr == EEMAC_ADDR_CONTROL |=> reg_rdata[6:4] == 3'b000;
    endproperty
    a_ctl_gap: assert property (p_ctl_gap) else $error("control gap bits set");

    property p_prog_no_wr;
        @(posedge clk) disable iff (rst || por)
            ctl_wr && reg_wdata[EEMAC_CTL_WR_TRIG] && st_q.mem_sel && !st_q.wr_trig
            |=> !st_q.wr_trig;
    endproperty
    a_prog_no_wr: assert property (p_prog_no_wr) else $error("program write started");

    sequence s_wr_end;
        st_q.state == EEMAC_WRITE && ee_wr_done && !wr_abort;
    endsequence

    property p_wr_done;
        @(posedge clk) disable iff (rst || por) s_wr_end |=> !st_q.wr_trig && !ee_wr;
    endproperty
    a_wr_done: assert property (p_wr_done) else $error("write trigger not cleared");

    property p_rdata_idle;
        @(posedge clk) disable iff (rst || por) !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its cycle");

endmodule

// file: tb/eemac_array_model.sv
// Purpose: Behavioural model of the data and program arrays behind the block
// Assumes: Reads answer in the strobe cycle; a write lasts wr_delay+1 cycles
// Notes: Idle read lines show inverted data, so a stale value never passes
`timescale 1ns/1ps
module eemac_array_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] wr_delay,
    input wire logic [12:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    input wire logic ee_rd,
    input wire logic ee_wr,
    input wire logic prog_rd,
    output logic [7:0] ee_rdata,
    output logic [13:0] prog_rdata,
    output logic ee_wr_done
);
    logic [7:0] ee_mem [0:255];
    logic [7:0] cnt_q;
    logic [13:0] pword;

    initial begin
        for (int i = 0; i < 256; i++) begin
            ee_mem[i] = 8'(i) ^ 8'h5A;
        end
    end

    // Word depends on every address bit, high byte included
    assign pword = {1'b0, mem_addr} ^ 14'h2A55;
    assign ee_rdata = ee_rd ? ee_mem[mem_addr[7:0]] : ~ee_mem[mem_addr[7:0]];
    assign prog_rdata = prog_rd ? pword : ~pword;

    // Aborted write (ee_wr dropped early) stores nothing
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 8'h00;
            ee_wr_done <= 1'b0;
        end else begin
            ee_wr_done <= 1'b0;
            if (ee_wr && !ee_wr_done) begin
                if (cnt_q == wr_delay) begin
                    ee_mem[mem_addr[7:0]] <= mem_wdata;
                    ee_wr_done <= 1'b1;
                    cnt_q <= 8'h00;
                end else begin
                    cnt_q <= cnt_q + 8'h01;
                end
            end else begin
                cnt_q <= 8'h00;
            end
        end
    end
endmodule

// file: tb/ee_memory_access_control_tb.sv
// Purpose: Self-checking bench for the memory access control block
// Assumes: Register port with read data in the cycle after the strobe
// Notes: Each access task leaves one idle cycle behind it
`timescale 1ns/1ps
module ee_memory_access_control_tb
    import eemac_pkg::*;
;
    logic clk, rst, por, ext_rst, wdt, reg_wr, reg_rd, irq;
    logic ee_rd, ee_wr, prog_rd, ee_wr_done;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, mem_wdata, ee_rdata, wr_delay;
    logic [12:0] mem_addr;
    logic [13:0] prog_rdata;
    int checks, n_mismatch, cycles;

    eemac_ctrl dut (.clk(clk), .rst(rst), .por(por), .external_master_reset(ext_rst),
        .watchdog_timeout(wdt), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .ee_rd(ee_rd), .ee_wr(ee_wr),
        .prog_rd(prog_rd), .ee_rdata(ee_rdata), .prog_rdata(prog_rdata),
        .ee_wr_done(ee_wr_done));
    eemac_array_model m (.clk(clk), .rst(rst), .wr_delay(wr_delay), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .ee_rd(ee_rd), .ee_wr(ee_wr), .prog_rd(prog_rd),
        .ee_rdata(ee_rdata), .prog_rdata(prog_rdata), .ee_wr_done(ee_wr_done));

    // ----------------------------------------
    // Access and check tasks
    // ----------------------------------------
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge clk);
    endtask

    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic rc(input logic [3:0] a, input logic [7:0] e, input string n);
        logic [7:0] v;
        rd(a, v);
        chk(n, v, e);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Clock and hang guard
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        logic [7:0] v;
        {rst, por, ext_rst, wdt, reg_wr, reg_rd} = 6'b100000;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        wr_delay = 8'h14;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rc(EEMAC_ADDR_CONTROL, 8'h00, "ctl_reset");
        wr(EEMAC_ADDR_DATA_HIGH, 8'hFF);
        rc(EEMAC_ADDR_DATA_HIGH, 8'h3F, "data_high");
        wr(EEMAC_ADDR_ADDR_HIGH, 8'hFF);
        rc(EEMAC_ADDR_ADDR_HIGH, 8'h1F, "addr_high");
        wr(EEMAC_ADDR_CONTROL, 8'hFC);
        rc(EEMAC_ADDR_CONTROL, 8'h84, "ctl_layout");
        wr(EEMAC_ADDR_IRQ_MASK, 8'h0F);
        wr(EEMAC_ADDR_ADDR_LOW, 8'h12);
        wr(EEMAC_ADDR_CONTROL, 8'h04);
        // Trigger then read with no gap: the byte must already be there
        reg_addr <= EEMAC_ADDR_CONTROL;
        reg_wdata <= 8'h05;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= EEMAC_ADDR_DATA_LOW;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk("ee_next", reg_rdata, 8'h48);
        @(posedge clk);
        rc(EEMAC_ADDR_DATA_LOW, 8'h48, "ee_read");
        rc(EEMAC_ADDR_CONTROL, 8'h04, "rd_clear");
        chk("irq_on", {7'h00, irq}, 8'h01);
        rc(EEMAC_ADDR_IRQ_STATUS, 8'h01, "status_rd");
        chk("irq_off", {7'h00, irq}, 8'h00);
        repeat (5) @(posedge clk);
        rc(EEMAC_ADDR_DATA_LOW, 8'h48, "data_hold");
        wr(EEMAC_ADDR_DATA_LOW, 8'hC3);
        rc(EEMAC_ADDR_DATA_LOW, 8'hC3, "data_sw");
        // Slow array write; a zero written to the trigger must not end it
        wr(EEMAC_ADDR_ADDR_LOW, 8'h30);
        wr(EEMAC_ADDR_CONTROL, 8'h06);
        rc(EEMAC_ADDR_CONTROL, 8'h06, "wr_busy");
        wr(EEMAC_ADDR_CONTROL, 8'h04);
        rc(EEMAC_ADDR_CONTROL, 8'h06, "wr_zero");
        v = 8'h02;
        for (int i = 0; i < 40 && v[1] !== 1'b0; i++) rd(EEMAC_ADDR_CONTROL, v);
        chk("wr_done", v, 8'h04);
        chk("stored", m.ee_mem[8'h30], 8'hC3);
        wr(EEMAC_ADDR_CONTROL, 8'h00);
        wr(EEMAC_ADDR_DATA_LOW, 8'h77);
        wr(EEMAC_ADDR_CONTROL, 8'h02);
        rc(EEMAC_ADDR_CONTROL, 8'h00, "wr_blocked");
        chk("kept", m.ee_mem[8'h30], 8'hC3);
        rc(EEMAC_ADDR_IRQ_STATUS, 8'h0A, "status_wr");
        // Both abort sources, each cleared by writing zero to the flag
        wr(EEMAC_ADDR_CONTROL, 8'h04);
        for (int k = 0; k < 2; k++) begin
            wr(EEMAC_ADDR_CONTROL, 8'h06);
            if (k == 0) ext_rst <= 1'b1;
            else wdt <= 1'b1;
            @(posedge clk);
            ext_rst <= 1'b0;
            wdt <= 1'b0;
            rd(EEMAC_ADDR_CONTROL, v);
            chk("wr_error", v & 8'h08, 8'h08);
            // Wait past a full array write, so an unaborted write would show
            repeat (24) @(posedge clk);
            chk("aborted", m.ee_mem[8'h30], 8'hC3);
            wr(EEMAC_ADDR_CONTROL, 8'h04);
        end
        rc(EEMAC_ADDR_CONTROL, 8'h04, "err_clear");
        wr(EEMAC_ADDR_ADDR_LOW, 8'h34);
        wr(EEMAC_ADDR_CONTROL, 8'h84);
        wr(EEMAC_ADDR_CONTROL, 8'h85);
        rc(EEMAC_ADDR_DATA_LOW, 8'h61, "prog_low");
        rc(EEMAC_ADDR_DATA_HIGH, 8'h35, "prog_high");
        wr(EEMAC_ADDR_CONTROL, 8'h86);
        rc(EEMAC_ADDR_CONTROL, 8'h84, "prog_wr");
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rc(EEMAC_ADDR_CONTROL, 8'h00, "sel_reset");
        wr(EEMAC_ADDR_CONTROL, 8'h04);
        por <= 1'b1;
        @(posedge clk);
        por <= 1'b0;
        @(posedge clk);
        rc(EEMAC_ADDR_CONTROL, 8'h00, "por_permit");
        // Masked event first, then unmask the pending status
        wr(EEMAC_ADDR_CONTROL, 8'h01);
        @(posedge clk);
        chk("irq_masked", {7'h00, irq}, 8'h00);
        wr(EEMAC_ADDR_IRQ_MASK, 8'h01);
        chk("irq_unmask", {7'h00, irq}, 8'h01);
        rc(EEMAC_ADDR_IRQ_STATUS, 8'h01, "status_rd2");
        chk("irq_clear", {7'h00, irq}, 8'h00);
        wr(4'hF, 8'hFF);
        rc(4'hF, 8'h00, "unmapped");
        give_verdict();
    end
endmodule
